// ===== io_ctl_bus.sv
// Top level: APB registers, control bus line sourcing, globals and cells.
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none
module io_ctl_bus
    import io_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic                           SYS_CLK_I,
    input  wire logic                           RST_N_I,
    // APB slave
    input  wire logic                           PSEL_I,
    input  wire logic                           PENABLE_I,
    input  wire logic                           PWRITE_I,
    input  wire logic [11:0]                    PADDR_I,
    input  wire logic [31:0]                    PWDATA_I,
    output logic      [31:0]                    PRDATA_O,
    output logic                                PREADY_O,
    output logic                                PSLVERR_O,
    // Dedicated and chip-wide pins
    input  wire logic [NDED-1:0]                DED_IN_I,
    input  wire logic [NDCLK-1:0]               DCLK_I,
    input  wire logic                           DEV_CLR_N_I,
    input  wire logic                           DEV_OE_I,
    // Logic array side
    input  wire logic [NLINE-1:0][NBLK-1:0]     ROW_FIRST_LC_I,
    input  wire logic [ROW_CH_W-1:0]            ROW_CH_I,
    input  wire logic [COL_CH_W-1:0]            COL_CH_I,
    input  wire logic [NCELL-1:0]               LC_CE_I,
    input  wire logic [NCELL-1:0]               LC_OE_I,
    output logic      [NCELL-1:0][1:0]          ROW_DRV_O,
    output logic      [NCELL-1:0][1:0]          COL_DRV_O,
    output logic      [NGLOB-1:0]               GLOBAL_O,
    output logic      [NLINE-1:0]               BUS_LINE_O,
    // Device pins
    input  wire logic [NCELL-1:0]               PIN_I,
    output logic      [NCELL-1:0]               PIN_O,
    output logic      [NCELL-1:0]               PIN_OE_O
);
    typedef struct packed {
        logic [4:0]                  ctrl;
        line_src_t [NLINE-1:0]       line_src;
        cell_cfg_t [NCELL-1:0]       cell_cfg;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic [NGLOB-1:0]            glob;
        logic [NLINE-1:0]            line_q;
    } top_st_t;

    top_st_t            st_reg;
    top_st_t            st_next;
    logic [NLINE-1:0]   line;
    logic [NGLOB-1:0]   glob_val;
    cell_ctl_t          ctl;
    logic [NCELL-1:0]   cell_data;
    logic               setup;
    logic               access;
    logic [31:0]        rdata;
    logic               hit;
    logic               word_ok;
    logic [11:0]        line_end;
    logic [11:0]        cell_end;

    // Line value from its programmed source
    function automatic logic line_val(input line_src_t src,
                                      input logic [NDED-1:0] ded,
                                      input logic [NBLK-1:0] row_lc,
                                      input logic [COL_CH_W-1:0] col);
        logic v;
        v = 1'b0;
        unique case (src.mode)
            SRC_DED:     v = (src.idx < 4'(NDED)) ? ded[src.idx[2:0]] : 1'b0;
            SRC_ROW_LC:  v = row_lc[src.idx[2:0]];
            SRC_COL_ROW: v = col[src.idx];
            default:     v = 1'b0;
        endcase
        return v;
    endfunction

    // Word index inside a register window
    function automatic logic [11:0] win_idx(input logic [11:0] addr,
                                            input logic [11:0] base);
        return (addr - base) >> 2;
    endfunction

    always_comb begin
        for (int l = 0; l < NLINE; l++) begin
            line[l] = line_val(st_reg.line_src[l], DED_IN_I, ROW_FIRST_LC_I[l], COL_CH_I);
        end
        for (int k = 0; k < NGLOB; k++) begin
            glob_val[k] = st_reg.ctrl[k+1] ? line[glob_line(k)] : DED_IN_I[k];
        end
    end

    assign ctl.line      = line;
    assign ctl.dclk      = DCLK_I;
    assign ctl.dev_clr_n = DEV_CLR_N_I;
    // option gates the chip tristate pin
    assign ctl.tristate  = st_reg.ctrl[0] & ~DEV_OE_I;

    assign setup    = PSEL_I & ~PENABLE_I;
    assign access   = PSEL_I & PENABLE_I & st_reg.pready;
    assign word_ok  = (PADDR_I[1:0] == 2'h0);
    assign line_end = ADDR_LINE + 12'(4 * NLINE);
    assign cell_end = ADDR_CELL + 12'(4 * NCELL);

    always_comb begin
        rdata = 32'h0000_0000;
        hit   = word_ok;
        if (PADDR_I == ADDR_CTRL) begin
            rdata = {27'h0, st_reg.ctrl};
        end else if (PADDR_I == ADDR_STATUS) begin
            rdata = {16'h0, st_reg.glob, st_reg.line_q};
        end else if (PADDR_I == ADDR_STATE) begin
            rdata = {16'h0, PIN_OE_O, cell_data};
        end else if (PADDR_I >= ADDR_LINE && PADDR_I < line_end) begin
            rdata = {26'h0, st_reg.line_src[win_idx(PADDR_I, ADDR_LINE)]};
        end else if (PADDR_I >= ADDR_CELL && PADDR_I < cell_end) begin
            rdata = {14'h0, st_reg.cell_cfg[win_idx(PADDR_I, ADDR_CELL)]};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        st_next        = st_reg;
        st_next.glob   = glob_val;
        st_next.line_q = line;
        // Ready one cycle after setup, so every access takes two cycles
        st_next.pready = setup;
        if (setup) begin
            // Refused reads return zero, even inside a window
            st_next.prdata  = (PWRITE_I || !hit) ? 32'h0000_0000 : rdata;
            st_next.pslverr = ~hit || (PWRITE_I &&
                              (PADDR_I == ADDR_STATUS || PADDR_I == ADDR_STATE));
        end
        if (access && PWRITE_I && !st_reg.pslverr) begin
            if (PADDR_I == ADDR_CTRL) begin
                st_next.ctrl = PWDATA_I[4:0];
            end else if (PADDR_I >= ADDR_LINE && PADDR_I < line_end) begin
                st_next.line_src[win_idx(PADDR_I, ADDR_LINE)] = PWDATA_I[5:0];
            end else if (PADDR_I >= ADDR_CELL && PADDR_I < cell_end) begin
                st_next.cell_cfg[win_idx(PADDR_I, ADDR_CELL)] = PWDATA_I[17:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_reg      <= '0;
            st_reg.ctrl <= CTRL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    for (genvar c = 0; c < NCELL; c++) begin : g_cell
        io_cell_unit #(
            .CELL      (c)
        ) u_cell (
            .clk_i     (SYS_CLK_I),
            .rst_n_i   (RST_N_I),
            .cfg_i     (st_reg.cell_cfg[c]),
            .ctl_i     (ctl),
            .lc_ce_i   (LC_CE_I[c]),
            .lc_oe_i   (LC_OE_I[c]),
            .pin_i     (PIN_I[c]),
            .row_ch_i  (ROW_CH_I),
            .col_ch_i  (COL_CH_I),
            .pin_o     (PIN_O[c]),
            .pin_oe_o  (PIN_OE_O[c]),
            .row_drv_o (ROW_DRV_O[c]),
            .col_drv_o (COL_DRV_O[c]),
            .data_o    (cell_data[c])
        );
    end

    assign PRDATA_O   = st_reg.prdata;
    assign PREADY_O   = st_reg.pready;
    assign PSLVERR_O  = st_reg.pslverr;
    assign GLOBAL_O   = st_reg.glob;
    assign BUS_LINE_O = st_reg.line_q;

    a_ded_source: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RST_N_I && st_reg.line_src[0].mode == SRC_DED && st_reg.line_src[0].idx == 4'h0
        |=> BUS_LINE_O[0] == $past(DED_IN_I[0]))
        else $error("line not following dedicated pin");
    a_row_source: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        st_reg.line_src[3].mode == SRC_ROW_LC
        |=> BUS_LINE_O[3] == $past(ROW_FIRST_LC_I[3][st_reg.line_src[3].idx[2:0]]))
        else $error("line not following first logic cell");
    a_col_source: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        st_reg.line_src[8].mode == SRC_COL_ROW
        |=> BUS_LINE_O[8] == $past(COL_CH_I[st_reg.line_src[8].idx]))
        else $error("line not following column route");
    a_global_bus: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        st_reg.ctrl[4] |=> GLOBAL_O[3] == $past(line[LN_CLK_B]))
        else $error("global not driven from shared line");
    a_global_pin: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        RST_N_I && !st_reg.ctrl[1] |=> GLOBAL_O[0] == $past(DED_IN_I[0]))
        else $error("global not driven from dedicated pin");
    a_apb_ready: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        setup |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not a single cycle after setup");
    a_apb_unmapped: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        setup && PADDR_I == 12'h0fc |=> PSLVERR_O && PRDATA_O == 32'h0000_0000)
        else $error("unmapped address not refused");
    a_cfg_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        access && PWRITE_I && !PSLVERR_O && PADDR_I == ADDR_CELL
        |=> st_reg.cell_cfg[0] == $past(PWDATA_I[17:0]))
        else $error("cell configuration not stored");
    c_apb_write: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        access && PWRITE_I && PADDR_I == ADDR_CTRL);
    c_glob_int: cover property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        st_reg.ctrl[1] && line[LN_CLK_A]);
endmodule
`default_nettype wire

// ===== io_ctl_pkg.sv
// Constants, types and helpers for the I/O cell control bus.
`default_nettype none
package io_ctl_pkg;
    localparam int NLINE     = 12;
    localparam int NCELL     = 8;
    localparam int NDED      = 6;
    localparam int NDCLK     = 2;
    localparam int NGLOB     = 4;
    localparam int NBLK      = 8;
    localparam int ROW_CH_W  = 16;
    localparam int COL_STEP  = 2;
    localparam int COL_REACH = 4;
    localparam int COL_CH_W  = COL_STEP * (NCELL - 1) + COL_REACH;
    // Shared line positions
    localparam int LN_CE0    = 6;
    localparam int LN_CLK_A  = 6;
    localparam int LN_XOE_A  = 7;
    localparam int LN_CLR_A  = 8;
    localparam int LN_XOE_B  = 9;
    localparam int LN_CLR_B  = 10;
    localparam int LN_CLK_B  = 11;
    // Cell selector codes
    localparam logic [1:0] CLK_BUS_A = 2'h0;
    localparam logic [1:0] CLK_BUS_B = 2'h1;
    localparam logic [1:0] CLK_PIN0  = 2'h2;
    localparam logic [1:0] CLR_BUS_A = 2'h1;
    localparam logic [1:0] CLR_BUS_B = 2'h2;
    localparam logic [2:0] CE_ALWAYS = 3'h7;
    // Register byte addresses and control register reset value
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_STATE  = 12'h008;
    localparam logic [11:0] ADDR_LINE   = 12'h040;
    localparam logic [11:0] ADDR_CELL   = 12'h080;
    localparam logic [4:0]  CTRL_RST    = 5'h00;

    typedef enum logic [1:0] {SRC_DED, SRC_ROW_LC, SRC_COL_ROW} src_mode_t;

    typedef struct packed {
        logic [3:0] idx;
        logic [1:0] mode;
    } line_src_t;

    typedef struct packed {
        logic [3:0] mux_idx;
        logic       col_mode;
        logic       lc_ctl;
        logic [2:0] oe_sel;
        logic [2:0] ce_sel;
        logic [1:0] clr_sel;
        logic [1:0] clk_sel;
        logic       reg_used;
        logic       is_out;
    } cell_cfg_t;

    typedef struct packed {
        logic [NLINE-1:0] line;
        logic [NDCLK-1:0] dclk;
        logic             dev_clr_n;
        logic             tristate;
    } cell_ctl_t;

    function automatic int oe_line(input logic [2:0] sel);
        return (sel == 3'h6) ? LN_XOE_A : (sel == 3'h7) ? LN_XOE_B : int'(sel);
    endfunction

    function automatic int glob_line(input int k);
        return (k == 0) ? LN_CLK_A : (k == 1) ? LN_XOE_A : (k == 2) ? LN_XOE_B : LN_CLK_B;
    endfunction
endpackage
`default_nettype wire

// ===== io_cell_unit.sv
// One I/O cell: control selection, register, pin buffer and routing drivers.
`default_nettype none
module io_cell_unit
    import io_ctl_pkg::*;
#(
    parameter int CELL = 0
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // Configuration and controls
    input  wire cell_cfg_t            cfg_i,
    input  wire cell_ctl_t            ctl_i,
    input  wire logic                 lc_ce_i,
    input  wire logic                 lc_oe_i,
    // Pin and routing
    input  wire logic                 pin_i,
    input  wire logic [ROW_CH_W-1:0]  row_ch_i,
    input  wire logic [COL_CH_W-1:0]  col_ch_i,
    output logic                      pin_o,
    output logic                      pin_oe_o,
    output logic [1:0]                row_drv_o,
    output logic [1:0]                col_drv_o,
    output logic                      data_o
);
    typedef struct packed {
        logic       clk_prev;
        logic       data;
        logic       pin;
        logic       pin_oe;
        logic [1:0] row_drv;
        logic [1:0] col_drv;
    } cell_st_t;

    cell_st_t st_reg;
    cell_st_t st_next;
    logic     clk_sel;
    logic     edge_seen;
    logic     ce;
    logic     oe;
    logic     clr;
    logic     dsrc;
    logic     val;

    always_comb begin
        st_next = st_reg;
        unique case (cfg_i.clk_sel)
            CLK_BUS_A: clk_sel = ctl_i.line[LN_CLK_A];
            CLK_BUS_B: clk_sel = ctl_i.line[LN_CLK_B];
            CLK_PIN0:  clk_sel = ctl_i.dclk[0];
            default:   clk_sel = ctl_i.dclk[1];
        endcase
        edge_seen = clk_sel & ~st_reg.clk_prev;
        if (cfg_i.lc_ctl) begin
            ce = lc_ce_i;
            oe = lc_oe_i;
        end else begin
            ce = (cfg_i.ce_sel >= 3'h6) ? 1'b1 : ctl_i.line[LN_CE0 + int'(cfg_i.ce_sel)];
            oe = ctl_i.line[oe_line(cfg_i.oe_sel)];
        end
        clr = (cfg_i.clr_sel == CLR_BUS_A) ? ctl_i.line[LN_CLR_A] :
              (cfg_i.clr_sel == CLR_BUS_B) ? ctl_i.line[LN_CLR_B] : 1'b0;
        if (!cfg_i.is_out) begin
            dsrc = pin_i;
        end else if (cfg_i.col_mode) begin
            dsrc = col_ch_i[CELL * COL_STEP + int'(cfg_i.mux_idx[1:0])];
        end else begin
            dsrc = row_ch_i[cfg_i.mux_idx];
        end
        st_next.clk_prev = clk_sel;
        if (!ctl_i.dev_clr_n || clr) begin
            st_next.data = 1'b0;
        end else if (edge_seen && ce) begin
            st_next.data = dsrc;
        end
        val = cfg_i.reg_used ? st_reg.data : dsrc;
        st_next.pin = cfg_i.is_out & val;
        st_next.pin_oe = cfg_i.is_out & oe & ~ctl_i.tristate;
        st_next.row_drv = (!cfg_i.is_out && !cfg_i.col_mode) ? {2{val}} : 2'h0;
        st_next.col_drv = (!cfg_i.is_out && cfg_i.col_mode) ? {2{val}} : 2'h0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_o     = st_reg.pin;
    assign pin_oe_o  = st_reg.pin_oe;
    assign row_drv_o = st_reg.row_drv;
    assign col_drv_o = st_reg.col_drv;
    assign data_o    = st_reg.data;

    a_chip_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ctl_i.dev_clr_n |=> !st_reg.data)
        else $error("cell register not cleared by chip reset");
    a_gated_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctl_i.dev_clr_n && !clr && edge_seen && ce |=> st_reg.data == $past(dsrc))
        else $error("enabled clock edge did not capture");
    a_hold_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctl_i.dev_clr_n && !clr && !(edge_seen && ce) |=> $stable(st_reg.data))
        else $error("register changed without enabled edge");
    a_tristate_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctl_i.tristate |=> !pin_oe_o)
        else $error("pin driven during chip tristate");
    a_lc_oe_take: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_i.lc_ctl && cfg_i.is_out && !ctl_i.tristate |=> pin_oe_o == $past(lc_oe_i))
        else $error("logic cell output enable not followed");
    a_row_input: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !cfg_i.is_out && !cfg_i.col_mode |=> row_drv_o[0] == row_drv_o[1] && col_drv_o == 2'h0)
        else $error("row input drive mismatch");
    c_capture: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        ctl_i.dev_clr_n && edge_seen && ce && dsrc);
    c_tristate: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_i.is_out && oe ##1 ctl_i.tristate);
endmodule
`default_nettype wire

// ===== io_ctl_board.sv
// Board model: dedicated inputs, clock pins and pin pulls.
`default_nettype none
module io_ctl_board
    import io_ctl_pkg::*;
(
    // Clock
    input  wire logic             clk_i,
    // Bench controls
    input  wire logic [NDED-1:0]  ded_lvl_i,
    input  wire logic [NDED-1:0]  ded_tie_i,
    input  wire logic [NCELL-1:0] drv_en_i,
    input  wire logic [NCELL-1:0] drv_val_i,
    // Device pins
    input  wire logic [NCELL-1:0] pin_o_i,
    input  wire logic [NCELL-1:0] pin_oe_i,
    output logic      [NDED-1:0]  ded_o,
    output logic      [NDCLK-1:0] dclk_o,
    output logic      [NCELL-1:0] pin_i_o
);
    timeunit 1ns;
    timeprecision 100ps;
    assign ded_o = ded_lvl_i & ~ded_tie_i;
    // Pull-down keeps an undriven pin at a known level
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_en_i & drv_val_i);
    initial dclk_o = '0;
    // Clock pins stand still between pulses
    task automatic pulse(input int k);
        dclk_o[k] <= 1'b1;
        repeat (3) @(posedge clk_i);
        dclk_o[k] <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ===== io_cell_control_bus_test.sv
// Self-checking bench: registers, line sourcing, globals and cells.
`default_nettype none
module io_cell_control_bus_test
    import io_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                       clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic                       dev_clr_n, dev_oe;
    logic [11:0]                paddr;
    logic [31:0]                pwdata, prdata, rd, probe;
    logic [NDED-1:0]            ded_in, ded_lvl, ded_tie;
    logic [NDCLK-1:0]           dclk;
    logic [NLINE-1:0][NBLK-1:0] row_lc;
    logic [ROW_CH_W-1:0]        row_ch;
    logic [COL_CH_W-1:0]        col_ch;
    logic [NCELL-1:0]           lc_ce, lc_oe, pin_in, pin_out, pin_oe, drv_en, drv_val;
    logic [NCELL-1:0][1:0]      row_drv, col_drv;
    logic [NGLOB-1:0]           glob;
    logic [NLINE-1:0]           lines, want;
    cell_cfg_t                  cfg;
    int                         fails, cmp_count, sel;

    io_ctl_bus dut_u (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .DED_IN_I(ded_in), .DCLK_I(dclk),
        .DEV_CLR_N_I(dev_clr_n), .DEV_OE_I(dev_oe), .ROW_FIRST_LC_I(row_lc),
        .ROW_CH_I(row_ch), .COL_CH_I(col_ch), .LC_CE_I(lc_ce), .LC_OE_I(lc_oe),
        .ROW_DRV_O(row_drv), .COL_DRV_O(col_drv), .GLOBAL_O(glob),
        .BUS_LINE_O(lines), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe)
    );
    io_ctl_board board_u (
        .clk_i(clk), .ded_lvl_i(ded_lvl), .ded_tie_i(ded_tie), .drv_en_i(drv_en),
        .drv_val_i(drv_val), .pin_o_i(pin_out), .pin_oe_i(pin_oe), .ded_o(ded_in),
        .dclk_o(dclk), .pin_i_o(pin_in)
    );

    assign probe = (sel == 0) ? 32'(lines) : (sel == 1) ? 32'(glob) :
                   (sel == 2) ? 32'(pin_out) : (sel == 3) ? 32'(pin_oe) :
                   (sel == 4) ? 32'(row_drv) : 32'(col_drv);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    // Request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] e,
                        input logic ee);
        apb(1'b0, a, 32'h0);
        chk(name, e, rd);
        chk({name, " err"}, 32'(ee), 32'(err));
    endtask

    // Bounded wait, then one compare of the watched outputs
    task automatic wait_eq(input string name, input int s, input logic [31:0] e);
        sel = s;
        repeat (12) begin
            @(posedge clk);
            if (probe === e) break;
        end
        chk(name, e, probe);
    endtask

    task automatic set_lines(input int m);
        for (int i = 0; i < NLINE; i++) begin
            apb(1'b1, ADDR_LINE + 12'(4 * i), 32'({4'(m == 1 ? i % 8 : i), 2'(m)}));
        end
    endtask

    function automatic logic expl(input int m, input int i);
        case (m)
            0: return (i < NDED) ? ded_in[i] : 1'b0;
            1: return row_lc[i][i % 8];
            2: return col_ch[i];
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, ded_tie, drv_en, drv_val} = '0;
        {dev_clr_n, dev_oe, ded_lvl, lc_ce, lc_oe} = {2'h3, 6'h2d, 8'hff, 8'h00};
        row_lc = 96'h5a3c_96f0_0ff0_a55a_c33c_1e2d;
        row_ch = 16'h0020;
        col_ch = 18'h2a5d3;
        {fails, cmp_count, sel, want} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("ctrl", ADDR_CTRL, 32'h0, 1'b0);
        rchk("state", ADDR_STATE, 32'h0, 1'b0);
        rchk("cell cfg", ADDR_CELL, 32'h0, 1'b0);
        apb(1'b1, ADDR_LINE + 12'h02c, 32'hffffffff);
        rchk("last line", ADDR_LINE + 12'h02c, 32'h3f, 1'b0);
        rchk("past last line", ADDR_LINE + 12'h030, 32'h0, 1'b1);
        rchk("unmapped", 12'h0fc, 32'h0, 1'b1);
        rchk("unaligned", 12'h06d, 32'h0, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'hffffffff);
        chk("status write err", 32'h1, 32'(err));
        $display("registers done");
        for (int m = 0; m < 4; m++) begin
            set_lines(m);
            for (int i = 0; i < NLINE; i++) want[i] = expl(m, i);
            wait_eq("lines", 0, 32'(want));
            rchk("status", ADDR_STATUS, 32'({ded_in[3:0], want}), 1'b0);
        end
        $display("line sources done");
        set_lines(2);
        ded_tie <= 6'h0f;
        apb(1'b1, ADDR_CTRL, 32'h1e);
        wait_eq("globals", 1, 32'({col_ch[11], col_ch[9], col_ch[7], col_ch[6]}));
        $display("globals done");
        apb(1'b1, ADDR_CTRL, 32'h1);
        cfg = '0;
        cfg.is_out = 1'b1;
        cfg.mux_idx = 4'h5;
        for (int s = 0; s < 8; s++) begin
            cfg.oe_sel = 3'(s);
            apb(1'b1, ADDR_CELL, 32'(cfg));
            wait_eq("out enable", 3, 32'(col_ch[s < 6 ? s : (s == 6 ? 7 : 9)]));
        end
        wait_eq("row pin", 2, 32'h1);
        row_ch <= 16'h0010;
        wait_eq("row pin", 2, 32'h0);
        cfg.oe_sel = 3'h0;
        apb(1'b1, ADDR_CELL, 32'(cfg));
        dev_oe <= 1'b0;
        wait_eq("tristate", 3, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        wait_eq("option off", 3, 32'h1);
        dev_oe <= 1'b1;
        cfg.lc_ctl = 1'b1;
        apb(1'b1, ADDR_CELL, 32'(cfg));
        wait_eq("logic cell oe", 3, 32'h0);
        lc_oe <= 8'h01;
        wait_eq("logic cell oe", 3, 32'h1);
        cfg.lc_ctl = 1'b0;
        cfg.col_mode = 1'b1;
        cfg.mux_idx = 4'h2;
        apb(1'b1, ADDR_CELL, 32'(cfg));
        apb(1'b1, ADDR_CELL + 12'h004, 32'(cfg));
        wait_eq("column pins", 2, 32'h2);
        apb(1'b1, ADDR_CELL, 32'h0);
        apb(1'b1, ADDR_CELL + 12'h004, 32'h0);
        $display("output cells done");
        cfg = '0;
        cfg.reg_used = 1'b1;
        cfg.clk_sel = CLK_PIN0;
        cfg.ce_sel = CE_ALWAYS;
        apb(1'b1, ADDR_CELL + 12'h008, 32'(cfg));
        drv_en <= 8'h04;
        drv_val <= 8'h04;
        rchk("no edge", ADDR_STATE, 32'h0, 1'b0);
        board_u.pulse(0);
        rchk("pin clock 0", ADDR_STATE, 32'h4, 1'b0);
        wait_eq("row drive", 4, 32'h30);
        drv_val <= 8'h00;
        cfg.clk_sel = 2'h3;
        apb(1'b1, ADDR_CELL + 12'h008, 32'(cfg));
        board_u.pulse(0);
        rchk("other clock", ADDR_STATE, 32'h4, 1'b0);
        board_u.pulse(1);
        rchk("pin clock 1", ADDR_STATE, 32'h0, 1'b0);
        drv_val <= 8'h04;
        col_ch[LN_CE0] <= 1'b0;
        cfg.ce_sel = 3'h0;
        apb(1'b1, ADDR_CELL + 12'h008, 32'(cfg));
        board_u.pulse(1);
        rchk("enable low", ADDR_STATE, 32'h0, 1'b0);
        col_ch[LN_CE0] <= 1'b1;
        board_u.pulse(1);
        rchk("enable high", ADDR_STATE, 32'h4, 1'b0);
        cfg.col_mode = 1'b1;
        apb(1'b1, ADDR_CELL + 12'h008, 32'(cfg));
        wait_eq("column drive", 5, 32'h30);
        dev_clr_n <= 1'b0;
        board_u.pulse(1);
        rchk("chip reset", ADDR_STATE, 32'h0, 1'b0);
        dev_clr_n <= 1'b1;
        cfg.lc_ctl = 1'b1;
        apb(1'b1, ADDR_CELL + 12'h008, 32'(cfg));
        lc_ce <= 8'hfb;
        board_u.pulse(1);
        rchk("logic cell ce off", ADDR_STATE, 32'h0, 1'b0);
        lc_ce <= 8'hff;
        board_u.pulse(1);
        rchk("logic cell ce on", ADDR_STATE, 32'h4, 1'b0);
        $display("input cells done");
        close_out();
    end
endmodule
`default_nettype wire
